// *** design/hwlc_cfg.svh ***
/*
 * Constants of the halfword logic, compare and shift datapath: opcodes,
 * instruction form codes, bit positions and sizes.
 * Assumes it is included by its bare name after the package is compiled.
 */
`ifndef HWLC_CFG_SVH
`define HWLC_CFG_SVH

// ==========================================================================
// Opcodes
// ==========================================================================
`define HWLC_OP_XOR_RR 8'h07
`define HWLC_OP_XOR_RX 8'h47
`define HWLC_OP_XOR_RS 8'hC7
`define HWLC_OP_UCMP_RR 8'h05
`define HWLC_OP_UCMP_RX 8'h45
`define HWLC_OP_UCMP_RS 8'hC5
`define HWLC_OP_FCMP_RR 8'h29
`define HWLC_OP_FCMP_RX 8'h69
`define HWLC_OP_SHL_RS 8'hCF

// ==========================================================================
// Form codes (top two opcode bits) and field positions
// ==========================================================================
`define HWLC_FORM_RR 2'h0
`define HWLC_FORM_RX 2'h1
`define HWLC_FORM_RS 2'h3
`define HWLC_HW_SIGN 15
`define HWLC_FP_SIGN 31
`define HWLC_FP_FRAC_MSB 23
`define HWLC_NO_INDEX 4'h0
`define HWLC_ODD_REG 4'h1
`define HWLC_HW_ZERO 16'h0000
`define HWLC_FRAC_ZERO 24'h000000

`endif

// *** design/hwlc_core.sv ***
/*
 * Execution datapath for halfword exclusive-OR, unsigned compare,
 * floating compare and arithmetic left shift, in RR, RX and RS forms.
 * Assumes an outside fetch unit presents one instruction at a time and a
 * memory port that answers each read with an acknowledge.
 */
// Notes on behaviour
// [RULE1] Exclusive-OR writes first operand register
// [RULE2] Immediate exclusive-OR uses address sum
// [RULE3] Unsigned compare sets condition code only
// [RULE4] Compare by subtracting, difference discarded
// [RULE5] Immediate compare uses address sum
// [RULE6] Float compare algebraic, operands unchanged
// [RULE7] Float compare greater less encoding
// [RULE8] Shifted bits pass through carry
// [RULE9] Carry holds last bit out
// [RULE10] Shift count is low four bits
// [RULE11] Shift address field unsigned, no memory
// [RULE12] Zero shift keeps register, sets code
// [RULE13] Left arithmetic keeps sign, zero fill
// [RULE14] Shift sets greater less from result
// [RULE15] Opcode, register, index, address field layout
// [RULE16] Logic ops set greater less flags
// [RULE17] Index field zero adds nothing
`timescale 1ns/1ns
`default_nettype none
`include "hwlc_cfg.svh"

module hwlc_core (
    input wire logic clock, // 125 MHz processor clock
    input wire logic rst_b, // Async reset, active low
    input wire logic start, // Instruction valid, taken while idle
    input wire hwlc_pkg::hwlc_instr_t instr, // Instruction word
    output logic busy, // Instruction in progress
    output logic done_q, // One-cycle completion pulse
    output logic illegal_q, // Last opcode not handled here
    output hwlc_pkg::hwlc_cc_t cc_q, // Condition code bits 12 to 15
    output logic mem_req_q, // Memory read request
    output logic [15:0] mem_addr_q, // Memory read address
    input wire logic mem_ack, // Memory data valid
    input wire logic [31:0] mem_rdata, // Memory data, halfword in low bits
    input wire logic gpr_wr_en, // Register load, honoured while idle
    input wire logic [3:0] gpr_wr_addr, // Register load address
    input wire logic [15:0] gpr_wr_data, // Register load data
    input wire logic [3:0] gpr_rd_addr, // Register peek address, idle only
    output logic [15:0] gpr_rd_data // Register peek data, next cycle
);
    import hwlc_pkg::*;

    // ======================================================================
    // Decoding
    // ======================================================================
    // [RULE15] Opcode to operation class
    function automatic hwlc_op_t op_decode(input logic [7:0] op);
        case (op)
            `HWLC_OP_XOR_RR, `HWLC_OP_XOR_RX, `HWLC_OP_XOR_RS: op_decode = OP_XOR;
            `HWLC_OP_UCMP_RR, `HWLC_OP_UCMP_RX, `HWLC_OP_UCMP_RS: op_decode = OP_UCMP;
            `HWLC_OP_FCMP_RR, `HWLC_OP_FCMP_RX: op_decode = OP_FCMP;
            `HWLC_OP_SHL_RS: op_decode = OP_SHL;
            default: op_decode = OP_BAD;
        endcase
    endfunction

    // Greater and less bits of a signed halfword result
    function automatic logic [1:0] sign_gl(input logic [15:0] v);
        sign_gl = {~v[`HWLC_HW_SIGN] && (v != `HWLC_HW_ZERO), v[`HWLC_HW_SIGN]};
    endfunction

    // [RULE6] Sign, exponent, fraction ordering
    // Magnitude order of {exponent, fraction} holds for normalised numbers only
    function automatic logic [1:0] fcmp_gl(input logic [31:0] a, input logic [31:0] b);
        logic a_zero;
        logic b_zero;
        logic a_neg;
        logic b_neg;
        logic [30:0] a_mag;
        logic [30:0] b_mag;
        a_zero = (a[`HWLC_FP_FRAC_MSB:0] == `HWLC_FRAC_ZERO);
        b_zero = (b[`HWLC_FP_FRAC_MSB:0] == `HWLC_FRAC_ZERO);
        a_neg = a[`HWLC_FP_SIGN] && !a_zero;
        b_neg = b[`HWLC_FP_SIGN] && !b_zero;
        a_mag = a_zero ? '0 : a[30:0];
        b_mag = b_zero ? '0 : b[30:0];
        if (a_neg == b_neg && a_mag == b_mag) begin
            fcmp_gl = 2'h0;
        end else if (a_neg != b_neg) begin
            fcmp_gl = a_neg ? 2'h1 : 2'h2;
        end else if (a_mag > b_mag) begin
            fcmp_gl = a_neg ? 2'h1 : 2'h2;
        end else begin
            fcmp_gl = a_neg ? 2'h2 : 2'h1;
        end
    endfunction

    // ======================================================================
    // State and operands
    // ======================================================================
    hwlc_state_t state_q;
    hwlc_instr_t instr_q;
    logic [31:0] op1_q;
    logic [31:0] op2_q;
    logic [15:0] ea_q;
    hwlc_op_t opc;
    logic [1:0] form;
    logic [15:0] rd_a;
    logic [15:0] rd_b;
    logic [3:0] rd_a_addr;
    logic [3:0] rd_b_addr;
    logic [15:0] idx;
    logic [15:0] ea_d;
    logic rf_wr_en;
    logic [3:0] rf_wr_addr;
    logic [15:0] rf_wr_data;
    logic sh_start;
    logic sh_done;
    logic [15:0] sh_data;
    logic sh_carry;
    logic [15:0] xor_res;
    logic [16:0] diff;
    logic exec_write;

    assign opc = op_decode(instr_q.op);
    assign form = instr_q.op[7:6];
    assign busy = (state_q != ST_IDLE);
    assign gpr_rd_data = rd_a;

    // [RULE17] Index field zero
    assign idx = (instr_q.x2 == `HWLC_NO_INDEX) ? `HWLC_HW_ZERO : rd_b;
    // [RULE11] Address field as unsigned count or operand, wraps at 16 bits
    assign ea_d = instr_q.addr + idx;

    // Read addresses: first pass high words, second pass odd partners
    always_comb begin
        if (state_q == ST_RDA) begin
            rd_a_addr = instr_q.r1 | `HWLC_ODD_REG;
            rd_b_addr = instr_q.x2 | `HWLC_ODD_REG;
        end else if (state_q == ST_IDLE && start) begin
            rd_a_addr = instr.r1;
            rd_b_addr = instr.x2;
        end else begin
            rd_a_addr = gpr_rd_addr;
            rd_b_addr = instr_q.x2;
        end
    end

    // ======================================================================
    // Result datapath
    // ======================================================================
    // [RULE1] Exclusive-OR result
    assign xor_res = op1_q[31:16] ^ op2_q[15:0];
    // [RULE4] Subtract, keep only the borrow and zero
    assign diff = {1'b0, op1_q[31:16]} - {1'b0, op2_q[15:0]};
    // [RULE3] Only exclusive-OR and shift write back
    assign exec_write = (state_q == ST_EXEC) && (opc == OP_XOR || opc == OP_SHL);

    // Register writes; outside loads lose to nothing since they wait for idle
    always_comb begin
        rf_wr_en = exec_write || (gpr_wr_en && state_q == ST_IDLE);
        rf_wr_addr = exec_write ? instr_q.r1 : gpr_wr_addr;
        if (!exec_write) begin
            rf_wr_data = gpr_wr_data;
        end else if (opc == OP_SHL) begin
            rf_wr_data = sh_data;
        end else begin
            rf_wr_data = xor_res;
        end
    end

    hwlc_regfile #(.W(16), .DEPTH(16), .AW(4)) u_regfile (
        .clock(clock),
        .rst_b(rst_b),
        .rd_a_addr(rd_a_addr),
        .rd_b_addr(rd_b_addr),
        .rd_a_q(rd_a),
        .rd_b_q(rd_b),
        .wr_en(rf_wr_en),
        .wr_addr(rf_wr_addr),
        .wr_data(rf_wr_data)
    );

    // [RULE10] Low four bits of the sum
    assign sh_start = (state_q == ST_RDA) && (opc == OP_SHL);

    hwlc_shifter #(.W(16), .CW(4)) u_shifter (
        .clock(clock),
        .rst_b(rst_b),
        .start(sh_start),
        .data_in(rd_a),
        .count(ea_d[3:0]),
        .carry_in(cc_q.c),
        .busy_q(),
        .done_q(sh_done),
        .data_q(sh_data),
        .carry_q(sh_carry)
    );

    // ======================================================================
    // Sequencer
    // ======================================================================
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            state_q <= ST_IDLE;
        end else begin
            case (state_q)
                ST_IDLE: begin
                    if (start) begin
                        state_q <= ST_RDA;
                    end
                end
                ST_RDA: begin
                    if (opc == OP_FCMP) begin
                        state_q <= ST_RDB;
                    end else if (opc == OP_SHL) begin
                        state_q <= ST_SHIFT;
                    end else if (opc != OP_BAD && form == `HWLC_FORM_RX) begin
                        state_q <= ST_MEM;
                    end else begin
                        state_q <= ST_EXEC;
                    end
                end
                ST_RDB: state_q <= (form == `HWLC_FORM_RX) ? ST_MEM : ST_EXEC;
                ST_MEM: state_q <= mem_ack ? ST_EXEC : ST_MEM;
                ST_SHIFT: state_q <= sh_done ? ST_EXEC : ST_SHIFT;
                ST_EXEC: state_q <= ST_IDLE;
                default: state_q <= ST_IDLE;
            endcase
        end
    end

    // Operand capture; halfword first operand sits in the top half
    // [RULE2] [RULE5] Immediate forms take the sum itself
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            instr_q <= '0;
            op1_q <= '0;
            op2_q <= '0;
            ea_q <= '0;
        end else if (state_q == ST_IDLE && start) begin
            instr_q <= instr;
        end else if (state_q == ST_RDA) begin
            op1_q[31:16] <= rd_a;
            op2_q <= {rd_b, (form == `HWLC_FORM_RS) ? ea_d : rd_b};
            ea_q <= ea_d;
        end else if (state_q == ST_RDB) begin
            op1_q[15:0] <= rd_a;
            op2_q[15:0] <= rd_b;
        end else if (state_q == ST_MEM && mem_ack) begin
            op2_q <= (opc == OP_FCMP) ? mem_rdata : {16'h0000, mem_rdata[15:0]};
        end
    end

    // Memory request held until acknowledged; shifts never go out
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            mem_req_q <= 1'b0;
            mem_addr_q <= '0;
        end else if (state_q == ST_RDB && form == `HWLC_FORM_RX) begin
            mem_req_q <= 1'b1;
            mem_addr_q <= ea_q;
        end else if (state_q == ST_RDA && opc != OP_FCMP && opc != OP_SHL
                     && opc != OP_BAD && form == `HWLC_FORM_RX) begin
            mem_req_q <= 1'b1;
            mem_addr_q <= ea_d;
        end else if (mem_ack) begin
            mem_req_q <= 1'b0;
        end
    end

    // Condition code; overflow bit is not touched by these operations
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            cc_q <= '0;
        end else if (state_q == ST_EXEC) begin
            case (opc)
                // [RULE16] Sign of exclusive-OR result
                OP_XOR: {cc_q.g, cc_q.l} <= sign_gl(xor_res);
                // [RULE16] Unsigned order from borrow
                OP_UCMP: begin
                    cc_q.c <= diff[16];
                    cc_q.g <= !diff[16] && (diff[15:0] != `HWLC_HW_ZERO);
                    cc_q.l <= diff[16];
                end
                // [RULE7] Greater less pair
                OP_FCMP: {cc_q.g, cc_q.l} <= fcmp_gl(op1_q, op2_q);
                // [RULE9] [RULE14] Carry and sign of result
                OP_SHL: begin
                    cc_q.c <= sh_carry;
                    {cc_q.g, cc_q.l} <= sign_gl(sh_data);
                end
                default: cc_q <= cc_q;
            endcase
        end
    end

    // Completion pulse and illegal flag
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            done_q <= 1'b0;
            illegal_q <= 1'b0;
        end else begin
            done_q <= (state_q == ST_EXEC);
            illegal_q <= (state_q == ST_EXEC) ? (opc == OP_BAD) : illegal_q;
        end
    end

    // ======================================================================
    // Checks
    // ======================================================================
    property p_xor_result;
        @(posedge clock) disable iff (!rst_b)
        (state_q == ST_EXEC && opc == OP_XOR)
            |-> rf_wr_en && rf_wr_addr == instr_q.r1 ##1 cc_q.l == $past(xor_res[15]);
    endproperty
    a_xor_result: assert property (p_xor_result) else $error("xor result wrong"); // [RULE1]

    property p_cmp_nowrite;
        @(posedge clock) disable iff (!rst_b)
        (state_q == ST_EXEC && (opc == OP_UCMP || opc == OP_FCMP)) |-> !rf_wr_en;
    endproperty
    a_cmp_nowrite: assert property (p_cmp_nowrite) else $error("compare wrote register"); // [RULE3]

    property p_ucmp_cc;
        @(posedge clock) disable iff (!rst_b)
        (state_q == ST_EXEC && opc == OP_UCMP)
            |=> cc_q.l == ($past(op1_q[31:16]) < $past(op2_q[15:0])) && cc_q.c == cc_q.l
                && cc_q.g == ($past(op1_q[31:16]) > $past(op2_q[15:0]));
    endproperty
    a_ucmp_cc: assert property (p_ucmp_cc) else $error("unsigned compare code wrong"); // [RULE4]

    property p_fcmp_excl;
        @(posedge clock) disable iff (!rst_b)
        (state_q == ST_EXEC && opc == OP_FCMP) |=> !(cc_q.g && cc_q.l)
            && ((cc_q.g || cc_q.l) == ($past(op1_q) != $past(op2_q)) || $past(op1_q[23:0]) == '0);
    endproperty
    a_fcmp_excl: assert property (p_fcmp_excl) else $error("float compare code wrong"); // [RULE7]

    property p_idx_zero;
        @(posedge clock) disable iff (!rst_b)
        (state_q == ST_RDA && instr_q.x2 == `HWLC_NO_INDEX) |=> ea_q == $past(instr_q.addr);
    endproperty
    a_idx_zero: assert property (p_idx_zero) else $error("index zero added data"); // [RULE17]

    property p_no_mem;
        @(posedge clock) disable iff (!rst_b)
        (state_q == ST_RDA && form != `HWLC_FORM_RX) |=> !mem_req_q;
    endproperty
    a_no_mem: assert property (p_no_mem) else $error("memory read in non-indexed form"); // [RULE11]

    property p_imm_operand;
        @(posedge clock) disable iff (!rst_b)
        (state_q == ST_RDA && form == `HWLC_FORM_RS && opc != OP_SHL)
            |=> op2_q[15:0] == ea_q ##1 !mem_req_q;
    endproperty
    a_imm_operand: assert property (p_imm_operand) else $error("immediate operand wrong"); // [RULE2]

    sequence s_shift_issue;
        sh_start ##1 (state_q == ST_SHIFT);
    endsequence
    property p_shift_done;
        @(posedge clock) disable iff (!rst_b)
        s_shift_issue |-> ##[1:17] (state_q == ST_EXEC) ##1 done_q;
    endproperty
    a_shift_done: assert property (p_shift_done) else $error("shift did not complete"); // [RULE10]

endmodule
`default_nettype wire

// *** design/hwlc_pkg.sv ***
/*
 * Types of the halfword logic, compare and shift datapath.
 * Assumes nothing of its surroundings.
 */
package hwlc_pkg;

    // ======================================================================
    // Instruction word, left justified; short forms use the top 16 bits
    // ======================================================================
    typedef struct packed {
        logic [7:0] op;
        logic [3:0] r1;
        logic [3:0] x2;
        logic [15:0] addr;
    } hwlc_instr_t;

    // Condition code, carry first, as in status word bits 12 to 15
    typedef struct packed {
        logic c;
        logic v;
        logic g;
        logic l;
    } hwlc_cc_t;

    typedef enum logic [2:0] {OP_XOR, OP_UCMP, OP_FCMP, OP_SHL, OP_BAD} hwlc_op_t;

    typedef enum {ST_IDLE, ST_RDA, ST_RDB, ST_MEM, ST_SHIFT, ST_EXEC} hwlc_state_t;

endpackage

// *** design/hwlc_regfile.sv ***
/*
 * General register file: two read ports with registered data, one write.
 * Assumes the caller loads every register before use; storage has no reset.
 */
`timescale 1ns/1ns
`default_nettype none

module hwlc_regfile #(
    parameter int W = 16,
    parameter int DEPTH = 16,
    parameter int AW = 4
) (
    input wire logic clock, // Processor clock
    input wire logic rst_b, // Async reset, active low
    input wire logic [AW-1:0] rd_a_addr, // Read port A address
    input wire logic [AW-1:0] rd_b_addr, // Read port B address
    output logic [W-1:0] rd_a_q, // Port A data, one cycle later
    output logic [W-1:0] rd_b_q, // Port B data, one cycle later
    input wire logic wr_en, // Write strobe
    input wire logic [AW-1:0] wr_addr, // Write address
    input wire logic [W-1:0] wr_data // Write data
);

    // ======================================================================
    // Storage
    // ======================================================================
    logic [W-1:0] mem [DEPTH];

    // Storage left unreset so it maps to plain RAM
    always_ff @(posedge clock) begin
        if (wr_en) begin
            mem[wr_addr] <= wr_data;
        end
    end

    // Registered reads; a same-cycle write shows up one read later
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            rd_a_q <= '0;
            rd_b_q <= '0;
        end else begin
            rd_a_q <= mem[rd_a_addr];
            rd_b_q <= mem[rd_b_addr];
        end
    end

endmodule
`default_nettype wire

// *** design/hwlc_shifter.sv ***
/*
 * Arithmetic left shifter, one position per clock, with carry tracking.
 * Assumes start is a single-cycle pulse given only while not busy.
 */
`timescale 1ns/1ns
`default_nettype none

module hwlc_shifter #(
    parameter int W = 16,
    parameter int CW = 4
) (
    input wire logic clock, // Processor clock
    input wire logic rst_b, // Async reset, active low
    input wire logic start, // Load operand and count
    input wire logic [W-1:0] data_in, // Value to shift
    input wire logic [CW-1:0] count, // Positions to shift
    input wire logic carry_in, // Carry kept on a zero count
    output logic busy_q, // Shifting in progress
    output logic done_q, // One-cycle completion pulse
    output logic [W-1:0] data_q, // Shifted value
    output logic carry_q // Last bit shifted out
);

    logic [CW-1:0] left_q;

    // ======================================================================
    // Data path
    // ======================================================================
    // [RULE13] Sign held, zero fill
    // [RULE8] Bit leaving passes carry
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            data_q <= '0;
            carry_q <= 1'b0;
        end else if (start) begin
            data_q <= data_in;
            carry_q <= carry_in;
        end else if (busy_q) begin
            carry_q <= data_q[W-2];
            data_q <= {data_q[W-1], data_q[W-3:0], 1'b0};
        end
    end

    // [RULE12] Zero count finishes unaltered
    // Step counter; one cycle per position keeps the path short
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            left_q <= '0;
            busy_q <= 1'b0;
            done_q <= 1'b0;
        end else if (start) begin
            left_q <= count;
            busy_q <= (count != '0);
            done_q <= (count == '0);
        end else begin
            left_q <= busy_q ? left_q - 1'b1 : left_q;
            busy_q <= busy_q && (left_q != 1'b1);
            done_q <= busy_q && (left_q == 1'b1);
        end
    end

    // ======================================================================
    // Checks
    // ======================================================================
    property p_sh_bound;
        @(posedge clock) disable iff (!rst_b)
        start |-> ##[1:16] done_q;
    endproperty
    a_sh_bound: assert property (p_sh_bound) else $error("shift did not finish"); // [RULE10]

    property p_sh_step;
        @(posedge clock) disable iff (!rst_b)
        (busy_q && !start) |=> (carry_q == $past(data_q[W-2]))
            && (data_q[W-1] == $past(data_q[W-1])) && !data_q[0];
    endproperty
    a_sh_step: assert property (p_sh_step) else $error("shift step wrong"); // [RULE8]

    property p_sh_zero;
        @(posedge clock) disable iff (!rst_b)
        (start && count == '0) |=> done_q && (data_q == $past(data_in));
    endproperty
    a_sh_zero: assert property (p_sh_zero) else $error("zero shift altered data"); // [RULE12]

endmodule
`default_nettype wire

// *** dv/hwlc_tb.sv ***
/*
 * Self-checking bench for hwlc_core: halfword and float rows, then reset,
 * index zero and unknown opcode cases.
 * Assumes the design package and the constants header are compiled first.
 */
`timescale 1ns/1ns
`default_nettype none
`include "hwlc_cfg.svh"
module testbench;
    import hwlc_pkg::*;
    logic clock, rst_b, start, busy, done_q, illegal_q, mem_req_q, mem_ack, gpr_wr_en;
    hwlc_instr_t instr;
    hwlc_cc_t cc_q;
    logic [15:0] mem_addr_q, gpr_wr_data, gpr_rd_data, a, b;
    logic [31:0] mem_rdata;
    logic [3:0] gpr_wr_addr, gpr_rd_addr, m;
    logic [7:0] op;
    logic [19:0] e;
    logic [65:0] fr;
    int fails, samples_checked, cycles;
    // ======================================================================
    // Stimulus tables: opcode, first operand, second operand or count
    // ======================================================================
    logic [39:0] rows [10] = '{{`HWLC_OP_XOR_RR, 16'hA5F0, 16'h0FF0},
        {`HWLC_OP_XOR_RX, 16'h1234, 16'h1234}, {`HWLC_OP_XOR_RS, 16'h0001, 16'h8000},
        {`HWLC_OP_UCMP_RR, 16'h8000, 16'h7FFF}, {`HWLC_OP_UCMP_RX, 16'h0001, 16'hFFFF},
        {`HWLC_OP_UCMP_RS, 16'h4444, 16'h4444}, {`HWLC_OP_SHL_RS, 16'hC001, 16'h0000},
        {`HWLC_OP_SHL_RS, 16'h4001, 16'h0001}, {`HWLC_OP_SHL_RS, 16'h8003, 16'hFFF2},
        {`HWLC_OP_SHL_RS, 16'h2AAA, 16'h001F}};
    // Float pairs: first, second, expected greater and less bits
    logic [65:0] frows [4] = '{{32'h41100000, 32'h41200000, 2'h1},
        {32'hC1100000, 32'h41100000, 2'h1}, {32'hC1100000, 32'hC1200000, 2'h2},
        {32'h42100000, 32'h41F00000, 2'h2}};

    hwlc_core dut (.clock(clock), .rst_b(rst_b), .start(start), .instr(instr), .busy(busy),
        .done_q(done_q), .illegal_q(illegal_q), .cc_q(cc_q), .mem_req_q(mem_req_q),
        .mem_addr_q(mem_addr_q), .mem_ack(mem_ack), .mem_rdata(mem_rdata),
        .gpr_wr_en(gpr_wr_en), .gpr_wr_addr(gpr_wr_addr), .gpr_wr_data(gpr_wr_data),
        .gpr_rd_addr(gpr_rd_addr), .gpr_rd_data(gpr_rd_data));

    // Reference: result and {C,V,G,L}; shift walks one place at a time
    function automatic logic [19:0] model(logic [7:0] o, logic [15:0] x, y);
        logic [15:0] r;
        logic c;
        r = (o[3:0] == 4'h7) ? x ^ y : x;
        c = 1'h0;
        for (int i = 0; i < 16; i++) begin
            if (o == 8'hCF && i < y[3:0]) begin
                c = r[14];
                r = {r[15], r[13:0], 1'h0};
            end
        end
        if (o[3:0] == 4'h5) return {x, x < y, 1'h0, x > y, x < y};
        return {r, c, 1'h0, !r[15] && r != 16'h0000, r[15]};
    endfunction

    task automatic check(input logic [31:0] seen, input logic [31:0] expv);
        samples_checked++;
        if (seen !== expv) begin
            fails++;
            $display("Error at %0t: seen %h expected %h", $time, seen, expv);
        end
    endtask

    task automatic wr(input logic [3:0] ad, input logic [15:0] d);
        gpr_wr_en = 1'h1;
        gpr_wr_addr = ad;
        gpr_wr_data = d;
        @(negedge clock);
        gpr_wr_en = 1'h0;
    endtask

    task automatic peek(input logic [3:0] ad, input logic [15:0] expv);
        gpr_rd_addr = ad;
        @(negedge clock);
        check(gpr_rd_data, expv);
    endtask

    // Memory answers one cycle after each request; request address must equal ea, never in RS form
    task automatic run(input hwlc_instr_t i, input logic [31:0] md, input logic [15:0] ea);
        start = 1'h1;
        instr = i;
        mem_rdata = md;
        @(negedge clock);
        start = 1'h0;
        for (int k = 0; k < 60 && done_q !== 1'h1; k++) begin
            if (mem_req_q === 1'h1 && !mem_ack) check({i.op[7:6] != 2'h3, mem_addr_q}, {1'h1, ea});
            mem_ack = mem_req_q === 1'h1 && !mem_ack;
            @(negedge clock);
        end
        mem_ack = 1'h0;
        check(done_q, 1'h1);
    endtask

    task automatic final_report;
        $display("Checks %0d, mismatches %0d", samples_checked, fails);
        if (fails == 0 && samples_checked > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    // ======================================================================
    // Clock, hang guard and main sequence
    // ======================================================================
    initial begin
        clock = 1'h0;
        forever #4 clock = ~clock;
    end

    // Ceiling well above the few hundred cycles the tests need
    always @(posedge clock) begin
        cycles++;
        if (cycles == 5000) begin
            fails++;
            final_report();
        end
    end

    initial begin
        {rst_b, start, instr, mem_ack, mem_rdata, gpr_wr_en} = '0;
        {gpr_wr_addr, gpr_wr_data, gpr_rd_addr} = '0;
        repeat (8) @(negedge clock);
        rst_b = 1'h1;
        check({busy, done_q, cc_q}, 6'h00);
        for (int n = 0; n < 10; n++) begin
            {op, a, b} = rows[n];
            wr(4'h2, a);
            wr(4'h4, b);
            wr(4'h6, 16'h0010);
            e = model(op, a, b);
            m = (op[3:0] == 4'h5 || (op == 8'hCF && b[3:0] != 4'h0)) ? 4'hF : 4'h3;
            run({op, 4'h2, op[7:6] == 2'h0 ? 4'h4 : 4'h6, b - 16'h0010}, {16'h0, b}, b);
            check(cc_q & m, e[3:0] & m);
            check(illegal_q, 1'h0);
            peek(4'h2, e[19:4]);
            peek(4'h4, b);
            $display("Row %0d done", n);
        end
        for (int f = 0; f < 4; f++) begin
            fr = frows[f];
            wr(4'h2, fr[65:50]);
            wr(4'h3, fr[49:34]);
            wr(4'h4, fr[33:18]);
            wr(4'h5, fr[17:2]);
            wr(4'h6, 16'h0010);
            if (f[0]) run({8'h69, 4'h2, 4'h6, 16'h0100}, fr[33:2], 16'h0110);
            else run({8'h29, 4'h2, 4'h4, 16'h0000}, 32'h0, 16'h0);
            check(cc_q[1:0], fr[1:0]);
            peek(4'h2, fr[65:50]);
        end
        $display("Float compare done");
        // Reset in mid-shift clears the status outputs
        start = 1'h1;
        instr = {8'hCF, 4'h2, 4'h0, 16'h000F};
        @(negedge clock);
        start = 1'h0;
        repeat (3) @(negedge clock);
        rst_b = 1'h0;
        @(negedge clock);
        check({busy, done_q, cc_q}, 6'h00);
        rst_b = 1'h1;
        wr(4'h0, 16'h0005);
        wr(4'h2, 16'h0001);
        run({8'hCF, 4'h2, 4'h0, 16'h0001}, 32'h0, 16'h0);
        peek(4'h2, 16'h0002);
        run({8'h04, 4'h2, 4'h4, 16'h0000}, 32'h0, 16'h0);
        check(illegal_q, 1'h1);
        peek(4'h2, 16'h0002);
        $display("Reset and odd cases done");
        final_report();
    end
endmodule
`default_nettype wire
